/* File: verilog/pxb_crossbar.sv */
// design: peripheral pin select crossbar with apb register slave
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none

module pxb_crossbar
    import pxb_pkg::*;
#(
    parameter int NUM_INPUTS  = pxb_pkg::PXB_NUM_INPUTS,
    parameter int NUM_PINS    = pxb_pkg::PXB_NUM_PINS,
    parameter int NUM_SIGNALS = pxb_pkg::PXB_NUM_SIGNALS
)(
    input  wire logic                                CLK,
    input  wire logic                                NRST,
    input  wire logic                                NRST_WARM,
    input  wire logic                                PSEL,
    input  wire logic                                PENABLE,
    input  wire logic                                PWRITE,
    input  wire logic [pxb_pkg::PXB_ADDR_W-1:0]      PADDR,
    input  wire logic [31:0]                         PWDATA,
    input  wire logic [3:0]                          PSTRB,
    output logic                                     PREADY,
    output logic [31:0]                              PRDATA,
    output logic                                     PSLVERR,
    input  wire logic                                ONE_SHOT_LOCK_CONFIG,
    input  wire logic [NUM_PINS-1:0]                 PIN_IN,
    input  wire logic [NUM_PINS-1:0]                 PORT_OUTPUT_LATCH,
    input  wire logic [NUM_PINS-1:0]                 PIN_DIRECTION_CONTROL,
    input  wire logic [NUM_SIGNALS-1:0]              PERIPH_OUT,
    input  wire logic [NUM_SIGNALS-1:0]              PERIPH_DIR_OVERRIDE,
    input  wire logic [NUM_SIGNALS-1:0]              PERIPH_OE_N,
    output logic [NUM_PINS-1:0]                      PIN_OUT,
    output logic [NUM_PINS-1:0]                      PIN_OE_N,
    output logic [NUM_INPUTS-1:0]                    PERIPH_IN,
    output logic                                     SELECTION_LOCK_FLAG
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // six-bit codes and a 64-word page bound the pin and signal counts; the default table bounds the input count
    if (NUM_PINS < 1 || NUM_PINS > 64)
    begin : g_bad_pins
        $error("pin count must lie in 1..64");
    end
    if (NUM_SIGNALS < 1 || NUM_SIGNALS > 64)
    begin : g_bad_signals
        $error("signal count must lie in 1..64");
    end
    if (NUM_INPUTS < 1 || NUM_INPUTS > PXB_NUM_INPUTS)
    begin : g_bad_inputs
        $error("input count exceeds the default table");
    end

    // ****************************************************************
    // declarations
    // ****************************************************************
    // selections keep six-bit codes only; bits 7-6 are never stored
    logic [PXB_SEL_W-1:0] in_sel_ff  [NUM_INPUTS];
    logic [PXB_SEL_W-1:0] out_sel_ff [NUM_PINS];
    logic                 lock_ff;
    logic                 cleared_once_ff;
    pxb_seq_e             seq_ff;
    logic [NUM_PINS-1:0]  pin_meta_ff;
    logic [NUM_PINS-1:0]  pin_sync_ff;
    logic                 pready_ff;
    logic [31:0]          prdata_ff;
    logic                 pslverr_ff;
    logic [NUM_PINS-1:0]  pin_out_ff;
    logic [NUM_PINS-1:0]  pin_oe_n_ff;
    logic [NUM_INPUTS-1:0] periph_in_ff;

    logic                 access;
    logic                 wr_en;
    logic                 byte0_wr;
    logic                 hit_lock;
    logic                 hit_in;
    logic                 hit_out;
    logic [5:0]           word_idx;
    logic                 any_reset;
    logic [31:0]          nxt_prdata;
    logic [7:0]           wbyte;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // true when addr is an aligned word inside page, below count entries
    function automatic logic page_hit(
        input logic [PXB_ADDR_W-1:0] addr,
        input logic [3:0]            page,
        input int                    count
    );
        logic [6:0] idx;
        idx = {1'b0, addr[7:2]};
        return (addr[11:8] == page) && (addr[1:0] == 2'b00) && (int'(idx) < count);
    endfunction : page_hit

    // ****************************************************************
    // apb decode
    // ****************************************************************
    // the access phase is taken once; pready_ff closes it the next edge
    assign access    = PSEL && PENABLE && !pready_ff;
    assign wr_en     = access && PWRITE;
    // a write with byte lane 0 off changes nothing but still breaks the keys
    assign byte0_wr  = wr_en && PSTRB[0];
    assign wbyte     = PWDATA[7:0];
    assign word_idx  = PADDR[7:2];
    assign hit_lock  = (PADDR == PXB_LOCK_OFFSET);
    assign hit_in    = page_hit(PADDR, PXB_IN_PAGE, NUM_INPUTS);
    assign hit_out   = page_hit(PADDR, PXB_OUT_PAGE, NUM_PINS);
    assign any_reset = !NRST || !NRST_WARM;

    // ****************************************************************
    // apb response
    // ****************************************************************
    // read data is zero outside read answers, so a stray sample sees nothing
    always_comb
    begin
        nxt_prdata = 32'h0000_0000;
        if (hit_lock)
        begin
            nxt_prdata[PXB_LOCK_BIT] = lock_ff;
        end
        else if (hit_in)
        begin
            nxt_prdata[PXB_SEL_W-1:0] = in_sel_ff[word_idx];
        end
        else if (hit_out)
        begin
            nxt_prdata[PXB_SEL_W-1:0] = out_sel_ff[word_idx];
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff  <= access;
            prdata_ff  <= (access && !PWRITE) ? nxt_prdata : 32'h0000_0000;
            pslverr_ff <= access && !(hit_lock || hit_in || hit_out);
        end
    end

    // ****************************************************************
    // unlock sequence
    // ****************************************************************
    // any other register write between the keys breaks the sequence
    // reads between the keys leave the sequence where it stands
    always_ff @(posedge CLK)
    begin
        if (any_reset)
        begin
            seq_ff <= PXB_SEQ_IDLE;
        end
        else if (byte0_wr && hit_lock)
        begin
            unique case (seq_ff)
                PXB_SEQ_IDLE:
                begin
                    seq_ff <= (wbyte == PXB_UNLOCK_KEY1) ? PXB_SEQ_KEY1 : PXB_SEQ_IDLE;
                end
                PXB_SEQ_KEY1:
                begin
                    if (wbyte == PXB_UNLOCK_KEY2)
                    begin
                        seq_ff <= PXB_SEQ_ARMED;
                    end
                    else if (wbyte == PXB_UNLOCK_KEY1)
                    begin
                        seq_ff <= PXB_SEQ_KEY1;
                    end
                    else
                    begin
                        seq_ff <= PXB_SEQ_IDLE;
                    end
                end
                PXB_SEQ_ARMED:
                begin
                    seq_ff <= PXB_SEQ_IDLE;
                end
                default:
                begin
                    seq_ff <= PXB_SEQ_IDLE;
                end
            endcase
        end
        else if (wr_en)
        begin
            seq_ff <= PXB_SEQ_IDLE;
        end
    end

    // ****************************************************************
    // lock flag
    // ****************************************************************
    // lock register write is honoured even while locked, once armed
    // one-shot: a clear is refused once a set flag has been cleared;
    // setting stays allowed, so software can always close the lock
    always_ff @(posedge CLK)
    begin
        if (any_reset)
        begin
            lock_ff         <= PXB_LOCK_RESET;
            cleared_once_ff <= 1'b0;
        end
        else if (byte0_wr && hit_lock && seq_ff == PXB_SEQ_ARMED)
        begin
            if (wbyte[PXB_LOCK_BIT])
            begin
                lock_ff <= 1'b1;
            end
            else if (!(ONE_SHOT_LOCK_CONFIG && cleared_once_ff))
            begin
                lock_ff         <= 1'b0;
                cleared_once_ff <= cleared_once_ff || lock_ff;
            end
        end
    end

    // ****************************************************************
    // selection registers
    // ****************************************************************
    // only the power-on reset reaches these; the warm reset does not
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            for (int i = 0; i < NUM_INPUTS; i++)
            begin
                in_sel_ff[i] <= PXB_IN_DEFAULT[i];
            end
        end
        else if (byte0_wr && hit_in && !lock_ff)
        begin
            // unsupported codes are stored as written; the input reads zero
            in_sel_ff[word_idx] <= wbyte[PXB_SEL_W-1:0];
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            for (int p = 0; p < NUM_PINS; p++)
            begin
                out_sel_ff[p] <= PXB_OUT_RESET;
            end
        end
        else if (byte0_wr && hit_out && !lock_ff)
        begin
            out_sel_ff[word_idx] <= wbyte[PXB_SEL_W-1:0];
        end
    end

    // ****************************************************************
    // pin input synchroniser
    // ****************************************************************
    // pin levels are asynchronous; only the second stage feeds the routing
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
        end
        else
        begin
            pin_meta_ff <= PIN_IN;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // ****************************************************************
    // input routing
    // ****************************************************************
    // codes beyond the pin count feed a quiet low rather than an unknown
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            periph_in_ff <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_INPUTS; i++)
            begin
                if (int'(in_sel_ff[i]) < NUM_PINS)
                begin
                    periph_in_ff[i] <= pin_sync_ff[in_sel_ff[i]];
                end
                else
                begin
                    periph_in_ff[i] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // output routing
    // ****************************************************************
    // codes beyond the signal count drive low under port direction
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            pin_out_ff  <= '0;
            pin_oe_n_ff <= '1;
        end
        else
        begin
            for (int p = 0; p < NUM_PINS; p++)
            begin
                if (out_sel_ff[p] == PXB_OUT_LATCH)
                begin
                    pin_out_ff[p]  <= PORT_OUTPUT_LATCH[p];
                    pin_oe_n_ff[p] <= PIN_DIRECTION_CONTROL[p];
                end
                else if (int'(out_sel_ff[p]) < NUM_SIGNALS)
                begin
                    pin_out_ff[p] <= PERIPH_OUT[out_sel_ff[p]];
                    if (PERIPH_DIR_OVERRIDE[out_sel_ff[p]])
                    begin
                        pin_oe_n_ff[p] <= PERIPH_OE_N[out_sel_ff[p]];
                    end
                    else
                    begin
                        pin_oe_n_ff[p] <= PIN_DIRECTION_CONTROL[p];
                    end
                end
                else
                begin
                    pin_out_ff[p]  <= 1'b0;
                    pin_oe_n_ff[p] <= PIN_DIRECTION_CONTROL[p];
                end
            end
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign PREADY              = pready_ff;
    assign PRDATA              = prdata_ff;
    assign PSLVERR             = pslverr_ff;
    assign PIN_OUT             = pin_out_ff;
    assign PIN_OE_N            = pin_oe_n_ff;
    assign PERIPH_IN           = periph_in_ff;
    assign SELECTION_LOCK_FLAG = lock_ff;

endmodule : pxb_crossbar

`default_nettype wire

/* File: inc/pxb_pkg.sv */
// package: constants, register map and types of the pin crossbar
package pxb_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int PXB_NUM_INPUTS  = 36;
    localparam int PXB_NUM_PINS    = 36;
    localparam int PXB_NUM_SIGNALS = 38;
    localparam int PXB_SEL_W       = 6;
    localparam int PXB_ADDR_W      = 12;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [11:0] PXB_LOCK_OFFSET = 12'h000;
    localparam logic [3:0]  PXB_IN_PAGE     = 4'h1;
    localparam logic [3:0]  PXB_OUT_PAGE    = 4'h2;
    localparam int          PXB_LOCK_BIT    = 0;

    // ****************************************************************
    // unlock pattern and reset values
    // ****************************************************************
    localparam logic [7:0]  PXB_UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0]  PXB_UNLOCK_KEY2 = 8'haa;
    localparam logic [5:0]  PXB_OUT_RESET   = 6'h00;
    localparam logic        PXB_LOCK_RESET  = 1'b0;
    localparam logic [5:0]  PXB_OUT_LATCH   = 6'h00;

    // power-on default pin code of each input function, in register order
    localparam logic [5:0] PXB_IN_DEFAULT [PXB_NUM_INPUTS] = '{
        6'h08, 6'h04, 6'h10, 6'h0d, 6'h10, 6'h0d, 6'h10, 6'h0d, 6'h15, 6'h15,
        6'h15, 6'h12, 6'h11, 6'h15, 6'h0b, 6'h0c, 6'h08, 6'h08, 6'h08, 6'h03,
        6'h04, 6'h05, 6'h13, 6'h14, 6'h13, 6'h13, 6'h0f, 6'h0f, 6'h17, 6'h16,
        6'h00, 6'h01, 6'h0e, 6'h0f, 6'h0a, 6'h0c
    };

    // ****************************************************************
    // unlock sequence states
    // ****************************************************************
    typedef enum logic [1:0] {
        PXB_SEQ_IDLE  = 2'b00,
        PXB_SEQ_KEY1  = 2'b01,
        PXB_SEQ_ARMED = 2'b10
    } pxb_seq_e;

endpackage : pxb_pkg

/* File: verification/pxb_crossbar_checker.sv */
// checker: bus timing, read data and lock behaviour of the pin crossbar
`timescale 1ns/100ps
`default_nettype none
module pxb_crossbar_checker #(
    parameter int NUM_INPUTS = 36,
    parameter int NUM_PINS   = 36
)(
    input wire logic                  CLK,
    input wire logic                  NRST,
    input wire logic                  NRST_WARM,
    input wire logic                  PSEL,
    input wire logic                  PENABLE,
    input wire logic                  PWRITE,
    input wire logic [11:0]           PADDR,
    input wire logic [3:0]            PSTRB,
    input wire logic                  PREADY,
    input wire logic [31:0]           PRDATA,
    input wire logic                  PSLVERR,
    input wire logic [NUM_PINS-1:0]   PIN_OE_N,
    input wire logic [NUM_INPUTS-1:0] PERIPH_IN,
    input wire logic                  SELECTION_LOCK_FLAG
);
    // ****************************************************************
    // properties
    // ****************************************************************
    wire logic take = PSEL && PENABLE && !PREADY;
    wire logic lock_take = take && PWRITE && PADDR == 12'h000 && PSTRB[0];

    ready_after_take_a:
    assert property (@(posedge CLK) disable iff (!NRST) take |=> PREADY)
        else $error("no answer one cycle after a taken request");
    ready_one_cycle_a:
    assert property (@(posedge CLK) disable iff (!NRST) PREADY |=> !PREADY)
        else $error("ready stood longer than one cycle");
    rdata_idle_zero_a:
    assert property (@(posedge CLK) disable iff (!NRST) !PREADY |-> PRDATA == 32'h0)
        else $error("read data not zero outside an answer");
    rdata_upper_zero_a:
    assert property (@(posedge CLK) disable iff (!NRST) PREADY |-> PRDATA[31:6] == 26'h0)
        else $error("unimplemented bits read as one");
    error_read_zero_a:
    assert property (@(posedge CLK) disable iff (!NRST) PSLVERR |-> PREADY && PRDATA == 32'h0)
        else $error("error answer without ready or with data");
    lock_cause_a:
    assert property (@(posedge CLK) disable iff (!NRST) $changed(SELECTION_LOCK_FLAG)
        |-> $past(lock_take) || !$past(NRST_WARM) || !$past(NRST))
        else $error("lock flag changed without a lock write");
    warm_clears_lock_a:
    assert property (@(posedge CLK) disable iff (!NRST) !NRST_WARM |=> !SELECTION_LOCK_FLAG)
        else $error("lock flag survived a warm reset");
    cold_reset_pins_a:
    assert property (@(posedge CLK) !NRST |=> &PIN_OE_N && PERIPH_IN == '0 && !SELECTION_LOCK_FLAG)
        else $error("outputs not at reset level after power-on reset");

    lock_set_c: cover property (@(posedge CLK) $rose(SELECTION_LOCK_FLAG));
    lock_clear_c: cover property (@(posedge CLK) $fell(SELECTION_LOCK_FLAG) && NRST_WARM);
    bus_error_c: cover property (@(posedge CLK) PSLVERR);
endmodule : pxb_crossbar_checker

bind pxb_crossbar pxb_crossbar_checker #(.NUM_INPUTS(NUM_INPUTS), .NUM_PINS(NUM_PINS)) i_chk (
    .CLK(CLK), .NRST(NRST), .NRST_WARM(NRST_WARM), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA),
    .PSLVERR(PSLVERR), .PIN_OE_N(PIN_OE_N), .PERIPH_IN(PERIPH_IN),
    .SELECTION_LOCK_FLAG(SELECTION_LOCK_FLAG)
);
`default_nettype wire

/* File: verification/pxb_periph_model.sv */
// partner: peripheral outputs and direction requests offered to the crossbar
`timescale 1ns/100ps
`default_nettype none
module pxb_periph_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hold,
    output logic [37:0]      periph_out,
    output logic [37:0]      periph_oe_n,
    output logic [37:0]      dir_override
);
    logic [37:0] pat_ff;
    logic [37:0] nxt_pat;

    // moves every cycle while hold is low, so that a stale route never matches by luck
    assign nxt_pat = {pat_ff[36:0], ~(pat_ff[37] ^ pat_ff[30])};
    always_ff @(posedge clk)
        if (!rst_n)
            pat_ff <= 38'h2b_5a3c_91e7;
        else if (!hold)
            pat_ff <= nxt_pat;
    assign periph_out   = pat_ff;
    assign periph_oe_n  = {pat_ff[0], pat_ff[37:1]} ^ 38'h15_5555_5555;
    assign dir_override = {pat_ff[18:0], pat_ff[37:19]};
endmodule : pxb_periph_model
`default_nettype wire

/* File: verification/peripheral_pin_select_registers_bench.sv */
// bench: self-checking test of the pin crossbar registers and routing
`timescale 1ns/100ps
`default_nettype none
module peripheral_pin_select_registers_bench;
    import pxb_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, nrst_warm = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, one_shot = 1'b0, hold = 1'b0, err;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rd;
    logic [3:0]  pstrb = 4'h1;
    logic [35:0] pin_in = 36'h0, latch = 36'h0, dir = 36'hf_ffff_ffff;
    wire  logic  pready, pslverr, lock_flag;
    wire  logic [31:0] prdata;
    wire  logic [37:0] p_out, p_dov, p_oe_n;
    wire  logic [35:0] pin_out, pin_oe_n, periph_in;
    int          num_errors = 0, cmp_count = 0, seed = 56, cycles = 0;

    pxb_crossbar i_dut (
        .CLK(clk), .NRST(nrst), .NRST_WARM(nrst_warm), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready),
        .PRDATA(prdata), .PSLVERR(pslverr), .ONE_SHOT_LOCK_CONFIG(one_shot), .PIN_IN(pin_in),
        .PORT_OUTPUT_LATCH(latch), .PIN_DIRECTION_CONTROL(dir), .PERIPH_OUT(p_out),
        .PERIPH_DIR_OVERRIDE(p_dov), .PERIPH_OE_N(p_oe_n), .PIN_OUT(pin_out),
        .PIN_OE_N(pin_oe_n), .PERIPH_IN(periph_in), .SELECTION_LOCK_FLAG(lock_flag)
    );
    pxb_periph_model i_periph (.clk(clk), .rst_n(nrst), .hold(hold), .periph_out(p_out),
        .periph_oe_n(p_oe_n), .dir_override(p_dov));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t: register %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_pin(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t: pin %b, expected %b", $time, got, exp);
        end
    endtask : chk_pin

    task automatic lock_seq(input logic v);
        apb(PXB_LOCK_OFFSET, 1'b1, {24'h0, PXB_UNLOCK_KEY1});
        apb(PXB_LOCK_OFFSET, 1'b1, {24'h0, PXB_UNLOCK_KEY2});
        apb(PXB_LOCK_OFFSET, 1'b1, {31'h0, v});
    endtask : lock_seq

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    function automatic logic [11:0] in_a(int i);
        return 12'h100 + 12'(4 * i);
    endfunction : in_a

    function automatic logic [11:0] out_a(int p);
        return 12'h200 + 12'(4 * p);
    endfunction : out_a

    function automatic logic [31:0] exp_sel(logic [7:0] d);
        return {26'h0, d[5:0]};
    endfunction : exp_sel

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            $display("MISMATCH %0t: run did not finish", $time);
            give_verdict();
        end
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        logic [7:0] w [36];
        logic [7:0] v [36];
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        apb(PXB_LOCK_OFFSET, 1'b0, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 36; i++)
        begin
            apb(in_a(i), 1'b0, 32'h0);
            chk(rd, {26'h0, PXB_IN_DEFAULT[i]});
            apb(out_a(i), 1'b0, 32'h0);
            chk(rd, 32'h0);
        end
        $display("test reset_values done");
        for (int i = 0; i < 36; i++)
        begin
            w[i] = {2'($random(seed)), 6'($unsigned($random(seed)) % (i == 0 ? 16 : 36))};
            v[i] = {2'($random(seed)), 6'($unsigned($random(seed)) % 38)};
            apb(in_a(i), 1'b1, {24'h0, w[i]});
            apb(out_a(i), 1'b1, {24'h0, v[i]});
        end
        for (int i = 0; i < 36; i++)
        begin
            apb(in_a(i), 1'b0, 32'h0);
            chk(rd, exp_sel(w[i]));
            apb(out_a(i), 1'b0, 32'h0);
            chk(rd, exp_sel(v[i]));
        end
        apb(12'h300, 1'b0, 32'h0);
        chk({rd[31:1], err}, 32'h1);
        $display("test readback done");
        apb(out_a(0), 1'b1, 32'h0);
        apb(out_a(1), 1'b1, 32'h3);
        apb(in_a(1), 1'b1, 32'h5);
        for (int k = 0; k < 6; k++)
        begin
            hold <= 1'b0;
            pin_in <= 36'({$random(seed), $random(seed)});
            latch <= 36'({$random(seed), $random(seed)});
            dir <= 36'({$random(seed), $random(seed)});
            @(posedge clk);
            hold <= 1'b1;
            repeat (4) @(posedge clk);
            chk_pin(pin_out[0], latch[0]);
            chk_pin(pin_oe_n[0], dir[0]);
            chk_pin(pin_out[1], p_out[3]);
            chk_pin(pin_oe_n[1], p_dov[3] ? p_oe_n[3] : dir[1]);
            chk_pin(periph_in[1], pin_in[5]);
        end
        $display("test routing done");
        lock_seq(1'b1);
        chk_pin(lock_flag, 1'b1);
        apb(in_a(3), 1'b1, 32'h07);
        apb(out_a(3), 1'b1, 32'h07);
        apb(in_a(3), 1'b0, 32'h0);
        chk(rd, exp_sel(w[3]));
        apb(out_a(3), 1'b0, 32'h0);
        chk(rd, exp_sel(v[3]));
        apb(PXB_LOCK_OFFSET, 1'b1, {24'h0, PXB_UNLOCK_KEY1});
        apb(in_a(4), 1'b1, 32'h0);
        apb(PXB_LOCK_OFFSET, 1'b1, {24'h0, PXB_UNLOCK_KEY2});
        apb(PXB_LOCK_OFFSET, 1'b1, 32'h0);
        chk_pin(lock_flag, 1'b1);
        lock_seq(1'b0);
        chk_pin(lock_flag, 1'b0);
        apb(in_a(3), 1'b1, 32'h07);
        apb(in_a(3), 1'b0, 32'h0);
        chk(rd, 32'h7);
        $display("test lock done");
        one_shot <= 1'b1;
        nrst_warm <= 1'b0;
        @(posedge clk);
        nrst_warm <= 1'b1;
        @(posedge clk);
        lock_seq(1'b1);
        lock_seq(1'b0);
        chk_pin(lock_flag, 1'b0);
        lock_seq(1'b1);
        lock_seq(1'b0);
        chk_pin(lock_flag, 1'b1);
        nrst_warm <= 1'b0;
        @(posedge clk);
        nrst_warm <= 1'b1;
        repeat (2) @(posedge clk);
        chk_pin(lock_flag, 1'b0);
        apb(in_a(3), 1'b0, 32'h0);
        chk(rd, 32'h7);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        apb(in_a(3), 1'b0, 32'h0);
        chk(rd, {26'h0, PXB_IN_DEFAULT[3]});
        $display("test one_shot_and_resets done");
        give_verdict();
    end
endmodule : peripheral_pin_select_registers_bench
`default_nettype wire
